// ### verilog/asm_session.sv
// session core: authentication flow, identifier, command counter
// assumes a frame layer that reports each whole command once, and an
// external aes/cmac engine that decrypts part 2 and derives the keys
//
// Summary of operation
// - fresh random 4-byte identifier each first authentication
// - 16-bit counter, cleared on first authentication
// - valid mac increments counter before response
// - command iv old counter, response iv new
// - counter at FFFFh gives integrity error for a command that keeps the session
// - chained command counts only once
// - mac is the even cmac bytes
// - cmac starts from zero vector
// - data uses aes-128 cbc, encryption session key
// - always append 80h, zero fill
// - authentication exchanges: no padding, zero iv
// - iv from label, identifier, counter low-first
// - other command aborts pending authentication
// - longer reader messages accepted if length consistent
// - refuse first authentication for missing key
// - part one: random challenge, clear counter, identifier
// - part two checks challenge, returns rotated reader challenge
// - success derives keys, failure leaves unauthenticated
// - followup refused unless authenticated or origin key
// - followup keeps identifier and counter, no capabilities
// - refuse aes request when card set leakage-resilient (code checks this for first authentication only, not for followup)
// - session keys from cmac over 32-byte vectors
`timescale 1ns/1ps

module asm_session (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // one pulse per completely received command
    input wire logic cmd_valid,
    input asm_pkg::asm_kind_e cmd_kind,
    input wire logic cmd_key_exists,
    input wire logic cmd_key_origin,
    input wire logic cmd_cap_len_ok,
    input wire logic cmd_mac_ok,
    input wire logic cmd_keeps_auth,
    // reader capabilities as received, and bytes present
    input wire logic [47:0] reader_capabilities,
    input wire logic [3:0] reader_cap_len,
    // decrypted part-2 body: reader challenge then rotated card challenge
    input wire logic [255:0] p2_plain,
    // random sources
    input wire logic [127:0] rnd_challenge,
    input wire logic [31:0] rnd_ident,
    // card configuration
    input wire logic [47:0] card_capabilities,
    // derived keys from the cmac engine
    input wire logic keys_valid,
    input wire logic [127:0] key_enc_in,
    input wire logic [127:0] key_mac_in,
    // cmac result and last block to pad
    input wire logic [127:0] cmac_full,
    input wire logic [127:0] pad_data,
    input wire logic [3:0] pad_len,
    // answer to the frame layer
    output logic resp_valid,
    output asm_pkg::asm_code_e resp_code,
    output logic [255:0] resp_data,
    // session status
    output logic authenticated,
    output logic auth_exchange,
    output logic [15:0] command_counter,
    output logic [31:0] transaction_identifier,
    // key derivation request and vectors
    output logic derive_req,
    output logic [255:0] sv_enc,
    output logic [255:0] sv_mac,
    output logic [127:0] session_encryption_key,
    output logic [127:0] session_mac_key,
    output logic [127:0] cmac_iv,
    // formatted blocks
    output logic [63:0] mac_trunc,
    output logic [127:0] pad_block,
    output logic [127:0] cmd_iv_block,
    output logic [127:0] rsp_iv_block
);

    // all state of the session core
    typedef struct packed {
        asm_pkg::asm_phase_e phase;
        logic auth; // authenticated state
        logic exch; // inside an authentication exchange
        logic followup; // pending exchange is a followup
        logic origin; // pending exchange targets an origin key
        logic [15:0] ctr;
        logic [31:0] txn_id;
        logic [127:0] card_chal;
        logic [127:0] rdr_chal;
        logic [47:0] rdr_cap;
        logic rvalid;
        asm_pkg::asm_code_e code;
        logic [255:0] data;
        logic derive;
        logic [127:0] kenc;
        logic [127:0] kmac;
    } asm_state_s;

    asm_state_s s_r;
    asm_state_s s_nxt;
    logic [47:0] cap_adj; // reader capabilities cut or zero filled
    logic card_lr_mode; // card configured for the other variant
    logic p1_ok; // first part one passes every check
    logic [127:0] ra; // stored reader challenge
    logic [127:0] rb; // stored card challenge
    logic [207:0] ctx; // mixed context of both challenges

    // bytes beyond the received length read as zero
    generate
        for (genvar b = 0; b < asm_pkg::CAP_BYTES; b++) begin : g_cap
            assign cap_adj[47-8*b -: 8] = (5'(b) < {1'b0, reader_cap_len})
                ? reader_capabilities[47-8*b -: 8] : 8'h00;
        end
    endgenerate

    assign card_lr_mode = card_capabilities[asm_pkg::CAP_MODE_BIT];
    // the reader's own mode bit does not matter: an aes answer lets it fall back
    assign p1_ok = cmd_key_exists && !cmd_key_origin && !card_lr_mode && cmd_cap_len_ok;

    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;
        s_nxt.derive = 1'b0;
        // keys land whenever the engine delivers them
        if (keys_valid) begin
            s_nxt.kenc = key_enc_in;
            s_nxt.kmac = key_mac_in;
        end
        if (cmd_valid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.data = '0;
            // anything but part two drops a pending exchange
            if (s_r.phase == asm_pkg::PH_WAIT_P2 && cmd_kind != asm_pkg::KIND_PART2) begin
                s_nxt.phase = asm_pkg::PH_IDLE;
                s_nxt.auth = 1'b0;
            end
            case (cmd_kind)
                // first authentication, part one
                asm_pkg::KIND_FIRST_P1: begin
                    s_nxt.auth = 1'b0;
                    if (!cmd_key_exists) begin
                        s_nxt.code = asm_pkg::RC_NO_SUCH_KEY;
                        s_nxt.exch = 1'b0;
                    end else if (cmd_key_origin || card_lr_mode) begin
                        s_nxt.code = asm_pkg::RC_PERMISSION_DENIED;
                        s_nxt.exch = 1'b0;
                    end else if (!cmd_cap_len_ok) begin
                        // longer messages pass as long as the length field agrees
                        s_nxt.code = asm_pkg::RC_LENGTH_ERROR;
                        s_nxt.exch = 1'b0;
                    end else begin
                        s_nxt.card_chal = rnd_challenge;
                        s_nxt.txn_id = rnd_ident;
                        s_nxt.ctr = asm_pkg::CTR_RESET;
                        s_nxt.rdr_cap = cap_adj;
                        s_nxt.phase = asm_pkg::PH_WAIT_P2;
                        s_nxt.exch = 1'b1;
                        s_nxt.followup = 1'b0;
                        s_nxt.origin = 1'b0;
                        s_nxt.code = asm_pkg::RC_ADDITIONAL_FRAME;
                        s_nxt.data = {rnd_challenge, 128'h0};
                    end
                end
                // followup authentication, part one
                asm_pkg::KIND_FOLLOWUP_P1: begin
                    if (!s_r.auth && !cmd_key_origin) begin
                        s_nxt.code = asm_pkg::RC_PERMISSION_DENIED;
                        s_nxt.exch = 1'b0;
                    end else if (!cmd_key_exists || !cmd_cap_len_ok) begin
                        s_nxt.code = cmd_key_exists ? asm_pkg::RC_LENGTH_ERROR
                                                    : asm_pkg::RC_NO_SUCH_KEY;
                        s_nxt.auth = 1'b0;
                        s_nxt.exch = 1'b0;
                    end else begin
                        // identifier and counter stay as they are
                        s_nxt.card_chal = rnd_challenge;
                        s_nxt.phase = asm_pkg::PH_WAIT_P2;
                        s_nxt.exch = 1'b1;
                        s_nxt.followup = 1'b1;
                        s_nxt.origin = cmd_key_origin;
                        s_nxt.code = asm_pkg::RC_ADDITIONAL_FRAME;
                        s_nxt.data = {rnd_challenge, 128'h0};
                    end
                end
                // part two of either authentication
                asm_pkg::KIND_PART2: begin
                    s_nxt.phase = asm_pkg::PH_IDLE;
                    if (s_r.phase != asm_pkg::PH_WAIT_P2) begin
                        s_nxt.code = asm_pkg::RC_AUTH_ERROR;
                        s_nxt.auth = 1'b0;
                        s_nxt.exch = 1'b0;
                    end else if (!cmd_cap_len_ok) begin
                        s_nxt.code = asm_pkg::RC_LENGTH_ERROR;
                        s_nxt.auth = 1'b0;
                        s_nxt.exch = 1'b0;
                    end else if (p2_plain[127:0] != asm_pkg::asm_rotl8(s_r.card_chal)) begin
                        // reader must send our challenge rotated by one byte
                        s_nxt.code = asm_pkg::RC_AUTH_ERROR;
                        s_nxt.auth = 1'b0;
                        s_nxt.exch = 1'b0;
                    end else begin
                        s_nxt.rdr_chal = p2_plain[255:128];
                        // an origin key proves the card but opens no session
                        s_nxt.auth = !s_r.origin;
                        s_nxt.derive = 1'b1;
                        s_nxt.code = asm_pkg::RC_OK;
                        if (s_r.followup) begin
                            s_nxt.data = {asm_pkg::asm_rotl8(p2_plain[255:128]), 128'h0};
                        end else begin
                            s_nxt.data = {asm_pkg::asm_rotl8(p2_plain[255:128]), s_r.txn_id,
                                          card_capabilities, s_r.rdr_cap};
                        end
                    end
                end
                // ordinary command, one pulse per whole chain
                default: begin
                    s_nxt.exch = 1'b0;
                    s_nxt.code = asm_pkg::RC_OK;
                    if (s_r.auth && s_r.phase != asm_pkg::PH_WAIT_P2) begin
                        if (!cmd_mac_ok || (cmd_keeps_auth && s_r.ctr == asm_pkg::CTR_MAX)) begin
                            // exhausted counter is treated like a bad mac
                            s_nxt.code = asm_pkg::RC_INTEGRITY_ERROR;
                            s_nxt.auth = 1'b0;
                        end else begin
                            s_nxt.ctr = s_r.ctr + 16'h0001;
                            s_nxt.auth = cmd_keeps_auth;
                        end
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // session vectors from both challenges
    assign ra = s_r.rdr_chal;
    assign rb = s_r.card_chal;
    assign ctx = {ra[127:112], ra[111:64] ^ rb[127:80], rb[79:0], ra[63:0]};
    assign sv_enc = {asm_pkg::SV_LABEL_ENC, asm_pkg::SV_COUNTER, asm_pkg::SV_LENGTH, ctx};
    assign sv_mac = {asm_pkg::SV_LABEL_MAC, asm_pkg::SV_COUNTER, asm_pkg::SV_LENGTH, ctx};

    // outputs straight from the state, except cmac_iv which is the constant ZERO_IV
    assign resp_valid = s_r.rvalid;
    assign resp_code = s_r.code;
    assign resp_data = s_r.data;
    assign authenticated = s_r.auth;
    assign auth_exchange = s_r.exch;
    assign command_counter = s_r.ctr;
    assign transaction_identifier = s_r.txn_id;
    assign derive_req = s_r.derive;
    assign session_encryption_key = s_r.kenc;
    assign session_mac_key = s_r.kmac;
    assign cmac_iv = asm_pkg::ZERO_IV;

    // iv blocks follow the live counter: old value before the command
    // completes, incremented value one clock after the answer is out
    asm_sm_format u_fmt (
        .clk(clk),
        .resetn(resetn),
        .cmac_full(cmac_full),
        .pad_data(pad_data),
        .pad_len(pad_len),
        .txn_id(s_r.txn_id),
        .ctr(s_r.ctr),
        .mac_trunc(mac_trunc),
        .pad_block(pad_block),
        .cmd_iv_block(cmd_iv_block),
        .rsp_iv_block(rsp_iv_block)
    );

    property p_inc;
        @(posedge clk) disable iff (!resetn)
        cmd_valid && cmd_kind == asm_pkg::KIND_OTHER && authenticated && !s_r.phase
            && cmd_mac_ok && command_counter != asm_pkg::CTR_MAX
        |=> command_counter == $past(command_counter) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("counter not advanced");

    property p_max;
        @(posedge clk) disable iff (!resetn)
        cmd_valid && cmd_kind == asm_pkg::KIND_OTHER && authenticated && !s_r.phase
            && cmd_keeps_auth && command_counter == asm_pkg::CTR_MAX
        |=> resp_code == asm_pkg::RC_INTEGRITY_ERROR && !authenticated;
    endproperty
    a_max: assert property (p_max) else $error("exhausted counter accepted");

    property p_once;
        @(posedge clk) disable iff (!resetn)
        !cmd_valid |=> command_counter == $past(command_counter);
    endproperty
    a_once: assert property (p_once) else $error("counter moved without command");

    property p_first;
        @(posedge clk) disable iff (!resetn)
        cmd_valid && cmd_kind == asm_pkg::KIND_FIRST_P1 && p1_ok
        |=> command_counter == asm_pkg::CTR_RESET && resp_code == asm_pkg::RC_ADDITIONAL_FRAME
            && transaction_identifier == $past(rnd_ident) && auth_exchange;
    endproperty
    a_first: assert property (p_first) else $error("part one not started");

    property p_nokey;
        @(posedge clk) disable iff (!resetn)
        cmd_valid && cmd_kind == asm_pkg::KIND_FIRST_P1 && !cmd_key_exists
        |=> resp_valid && resp_code == asm_pkg::RC_NO_SUCH_KEY && !authenticated;
    endproperty
    a_nokey: assert property (p_nokey) else $error("missing key accepted");

    property p_variant;
        @(posedge clk) disable iff (!resetn)
        cmd_valid && cmd_kind == asm_pkg::KIND_FIRST_P1 && cmd_key_exists && card_lr_mode
        |=> resp_code == asm_pkg::RC_PERMISSION_DENIED;
    endproperty
    a_variant: assert property (p_variant) else $error("variant clash accepted");

    property p_follow;
        @(posedge clk) disable iff (!resetn)
        cmd_valid && cmd_kind == asm_pkg::KIND_FOLLOWUP_P1 && !authenticated && !cmd_key_origin
        |=> resp_code == asm_pkg::RC_PERMISSION_DENIED && !authenticated;
    endproperty
    a_follow: assert property (p_follow) else $error("followup without session");

    property p_keep;
        @(posedge clk) disable iff (!resetn)
        cmd_valid && cmd_kind == asm_pkg::KIND_FOLLOWUP_P1
        |=> transaction_identifier == $past(transaction_identifier)
            && command_counter == $past(command_counter);
    endproperty
    a_keep: assert property (p_keep) else $error("followup changed session");

    property p_abort;
        @(posedge clk) disable iff (!resetn)
        cmd_valid && cmd_kind == asm_pkg::KIND_OTHER && s_r.phase == asm_pkg::PH_WAIT_P2
        |=> !authenticated && s_r.phase == asm_pkg::PH_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("pending exchange survived");

endmodule : asm_session

// ### verilog/asm_pkg.sv
// shared constants and types of the secure-messaging session logic
// assumes one 40 mhz clock and an external aes/cmac engine around the block
package asm_pkg;

    // command counter values
    localparam logic [15:0] CTR_RESET = 16'h0000;
    localparam logic [15:0] CTR_MAX = 16'hFFFF;
    // iv block labels, command then response
    localparam logic [15:0] IV_LABEL_CMD = 16'hA55A;
    localparam logic [15:0] IV_LABEL_RSP = 16'h5AA5;
    // session vector fields
    localparam logic [15:0] SV_LABEL_ENC = 16'hA55A;
    localparam logic [15:0] SV_LABEL_MAC = 16'h5AA5;
    localparam logic [15:0] SV_COUNTER = 16'h0001;
    localparam logic [15:0] SV_LENGTH = 16'h0080;
    // padding marker byte
    localparam logic [7:0] PAD_MARK = 8'h80;
    // all-zero start vector for cmac and for the authentication exchanges
    localparam logic [127:0] ZERO_IV = 128'h0;
    // mode bit in the capability field (byte 1, bit 1; byte 0 is the top byte)
    localparam int CAP_MODE_BIT = 33;
    // byte counts
    localparam int CAP_BYTES = 6;
    localparam int BLOCK_BYTES = 16;
    localparam int MAC_BYTES = 8;

    // kind of a completely received command
    typedef enum logic [1:0] {
        KIND_OTHER,
        KIND_FIRST_P1,
        KIND_FOLLOWUP_P1,
        KIND_PART2
    } asm_kind_e;

    // answer codes given to the frame layer
    typedef enum logic [2:0] {
        RC_OK,
        RC_ADDITIONAL_FRAME,
        RC_PERMISSION_DENIED,
        RC_NO_SUCH_KEY,
        RC_LENGTH_ERROR,
        RC_AUTH_ERROR,
        RC_INTEGRITY_ERROR
    } asm_code_e;

    // authentication progress
    typedef enum logic {
        PH_IDLE,
        PH_WAIT_P2
    } asm_phase_e;

    // rotate a 16-byte string left by one byte, top byte first
    function automatic logic [127:0] asm_rotl8(input logic [127:0] x);
        asm_rotl8 = {x[119:0], x[127:120]};
    endfunction : asm_rotl8

endpackage : asm_pkg

// ### verilog/asm_sm_format.sv
// formatting helpers: cmac truncation, block padding, iv blocks
// assumes the session core feeds identifier and counter; outputs lag one clock
`timescale 1ns/1ps

module asm_sm_format (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // full cmac result, top byte first
    input wire logic [127:0] cmac_full,
    // last partial block and its valid byte count
    input wire logic [127:0] pad_data,
    input wire logic [3:0] pad_len,
    // session values for the iv blocks
    input wire logic [31:0] txn_id,
    input wire logic [15:0] ctr,
    // registered results
    output logic [63:0] mac_trunc,
    output logic [127:0] pad_block,
    output logic [127:0] cmd_iv_block,
    output logic [127:0] rsp_iv_block
);

    // all state of this module
    typedef struct packed {
        logic [63:0] mac;
        logic [127:0] pad;
        logic [127:0] civ;
        logic [127:0] riv;
    } asm_fmt_s;

    asm_fmt_s s_r;
    asm_fmt_s s_nxt;
    logic [63:0] trunc_w; // even bytes of the cmac
    logic [127:0] pad_w; // padded block

    // keep bytes 0,2,..,14 counting from the top byte
    generate
        for (genvar i = 0; i < asm_pkg::MAC_BYTES; i++) begin : g_trunc
            assign trunc_w[63-8*i -: 8] = cmac_full[127-16*i -: 8];
        end
    endgenerate

    // marker always follows the data, so a full block of data
    // is sent with pad_len 0 and yields a whole padding block
    generate
        for (genvar b = 0; b < asm_pkg::BLOCK_BYTES; b++) begin : g_pad
            assign pad_w[127-8*b -: 8] =
                (5'(b) < {1'b0, pad_len}) ? pad_data[127-8*b -: 8] :
                (5'(b) == {1'b0, pad_len}) ? asm_pkg::PAD_MARK : 8'h00;
        end
    endgenerate

    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.mac = trunc_w;
        s_nxt.pad = pad_w;
        // counter goes in low byte first
        s_nxt.civ = {asm_pkg::IV_LABEL_CMD, txn_id, ctr[7:0], ctr[15:8], 64'h0};
        s_nxt.riv = {asm_pkg::IV_LABEL_RSP, txn_id, ctr[7:0], ctr[15:8], 64'h0};
    end

    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mac_trunc = s_r.mac;
    assign pad_block = s_r.pad;
    assign cmd_iv_block = s_r.civ;
    assign rsp_iv_block = s_r.riv;

    property p_trunc;
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> (mac_trunc[63:56] == $past(cmac_full[127:120]))
            && (mac_trunc[7:0] == $past(cmac_full[15:8]));
    endproperty
    a_trunc: assert property (p_trunc) else $error("mac truncation wrong");

    property p_iv;
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> (cmd_iv_block[127:112] == asm_pkg::IV_LABEL_CMD)
            && (rsp_iv_block[79:72] == $past(ctr[7:0]));
    endproperty
    a_iv: assert property (p_iv) else $error("iv block layout wrong");

endmodule : asm_sm_format

// ### tb/asm_reader_model.sv
// reader model: answers the card part-one challenge with a part-two body
// assumes the card challenge arrives in the top 16 bytes of each answer
`timescale 1ns/1ps

module asm_reader_model (
    // clock
    input wire logic clk,
    // card answer
    input wire logic resp_valid,
    input wire logic [255:0] resp_data,
    // own challenge, and a bad-rotation request from the bench
    input wire logic [127:0] reader_challenge,
    input wire logic corrupt,
    // part-two body as the card sees it after decryption
    output logic [255:0] p2_plain
);
    logic [127:0] card_chal_r; // last challenge seen from the card

    // keep every answer; only the part-one one is ever used
    always_ff @(posedge clk) begin
        if (resp_valid) begin
            card_chal_r <= resp_data[255:128];
        end
    end

    // own challenge, then card challenge rotated left one byte
    // corrupt flips the lowest bit so the card must refuse
    assign p2_plain = {reader_challenge, card_chal_r[119:0], card_chal_r[127:120]} ^
        {255'h0, corrupt};
endmodule : asm_reader_model

// ### tb/testbench.sv
// testbench: session core against the reader model, one task per scenario
// assumes a 40 mhz clock and answers one cycle after each command pulse
`timescale 1ns/1ps

module testbench;
    // stimulus, all changed at the falling edge
    logic clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, key_ex = 1'b1, key_or = 1'b0;
    logic mac_ok = 1'b1, keys_valid = 1'b0, corrupt = 1'b0, len_ok = 1'b1, keeps = 1'b1;
    asm_pkg::asm_kind_e kind = asm_pkg::KIND_OTHER;
    logic [47:0] rcap = 48'hA1B2C3D4E5F6, ccap = 48'h0;
    logic [3:0] rcap_len = 4'h6, pad_len = 4'h5;
    logic [127:0] rchal = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0, rnd_ch = 128'hC0FFEE;
    logic [127:0] cmac = 128'h00112233445566778899AABBCCDDEEFF, pad = 128'h1122334455 << 88;
    logic [127:0] kenc = 128'h5, kmac = 128'h6;
    logic [31:0] rnd_id = 32'h89ABCDEF;
    // observed outputs
    logic rv, auth, aex, dreq;
    asm_pkg::asm_code_e rc;
    logic [255:0] rd, p2, sve, svm;
    logic [127:0] kse, ksm, civ, pb, cib, rib;
    logic [63:0] mt;
    logic [15:0] ctr;
    logic [31:0] tid;
    int bad_count = 0, n_compared = 0;

    always #12.5 clk = ~clk;

    asm_session dut (
        .clk, .resetn, .cmd_valid, .cmd_kind(kind), .cmd_key_exists(key_ex),
        .cmd_key_origin(key_or), .cmd_cap_len_ok(len_ok), .cmd_mac_ok(mac_ok),
        .cmd_keeps_auth(keeps), .reader_capabilities(rcap), .reader_cap_len(rcap_len),
        .p2_plain(p2), .rnd_challenge(rnd_ch), .rnd_ident(rnd_id), .card_capabilities(ccap),
        .keys_valid, .key_enc_in(kenc), .key_mac_in(kmac), .cmac_full(cmac),
        .pad_data(pad), .pad_len, .resp_valid(rv), .resp_code(rc), .resp_data(rd),
        .authenticated(auth), .auth_exchange(aex), .command_counter(ctr),
        .transaction_identifier(tid), .derive_req(dreq), .sv_enc(sve), .sv_mac(svm),
        .session_encryption_key(kse), .session_mac_key(ksm), .cmac_iv(civ),
        .mac_trunc(mt), .pad_block(pb), .cmd_iv_block(cib), .rsp_iv_block(rib)
    );

    asm_reader_model reader (
        .clk, .resp_valid(rv), .resp_data(rd), .reader_challenge(rchal), .corrupt,
        .p2_plain(p2)
    );

    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    // one command pulse; returns at the falling edge where the answer stands
    task automatic pulse(input asm_pkg::asm_kind_e k);
        @(negedge clk);
        cmd_valid = 1'b1;
        kind = k;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : pulse

    task automatic send(input asm_pkg::asm_kind_e k, input asm_pkg::asm_code_e c);
        pulse(k);
        check(rv, 1'b1);
        check(rc, c);
    endtask : send

    task automatic t_refuse();
        key_ex = 1'b0;
        send(asm_pkg::KIND_FIRST_P1, asm_pkg::RC_NO_SUCH_KEY);
        key_ex = 1'b1;
        key_or = 1'b1;
        send(asm_pkg::KIND_FIRST_P1, asm_pkg::RC_PERMISSION_DENIED);
        key_or = 1'b0;
        ccap = 48'h000200000000; // mode bit 33: leakage-resilient
        send(asm_pkg::KIND_FIRST_P1, asm_pkg::RC_PERMISSION_DENIED);
        ccap = 48'h0;
        len_ok = 1'b0;
        send(asm_pkg::KIND_FIRST_P1, asm_pkg::RC_LENGTH_ERROR);
        len_ok = 1'b1;
        send(asm_pkg::KIND_FOLLOWUP_P1, asm_pkg::RC_PERMISSION_DENIED);
        check({auth, aex}, 2'b00);
        $display("test refusals done");
    endtask : t_refuse

    // len below six exercises the zero fill of the echoed caps
    task automatic t_first(input logic [3:0] len);
        logic [47:0] adj;
        adj = (len < 4'h6) ? {rcap[47:16], 16'h0} : rcap;
        rcap_len = len;
        rnd_id = rnd_id + 32'h1;
        send(asm_pkg::KIND_FIRST_P1, asm_pkg::RC_ADDITIONAL_FRAME);
        check({ctr, tid, aex, civ}, {16'h0, rnd_id, 1'b1, 128'h0});
        check(rd, {rnd_ch, 128'h0});
        send(asm_pkg::KIND_PART2, asm_pkg::RC_OK);
        check(rd, {rchal[119:0], rchal[127:120], rnd_id, ccap, adj});
        check({auth, dreq}, 2'b11);
        check(sve[255:192], {48'hA55A00010080, rchal[127:112]});
        check({svm[255:208], svm[63:0]}, {48'h5AA500010080, rchal[63:0]});
        keys_valid = 1'b1;
        @(negedge clk);
        keys_valid = 1'b0;
        @(negedge clk);
        check({kse, ksm}, {kenc, kmac});
        $display("test first authentication done");
    endtask : t_first

    task automatic t_count();
        logic [31:0] t0;
        t0 = tid;
        send(asm_pkg::KIND_OTHER, asm_pkg::RC_OK);
        check(ctr, 16'h1);
        @(negedge clk); // iv blocks see the counter one clock later
        check({cib, rib}, {16'hA55A, t0, 16'h0100, 64'h0, 16'h5AA5, t0, 16'h0100, 64'h0});
        check({mt, pb}, {64'h0022446688AACCEE, pad[127:88], 8'h80, 80'h0});
        pad_len = 4'h0;
        @(negedge clk);
        check(pb, {8'h80, 120'h0});
        rnd_id = 32'h0;
        send(asm_pkg::KIND_FOLLOWUP_P1, asm_pkg::RC_ADDITIONAL_FRAME);
        send(asm_pkg::KIND_PART2, asm_pkg::RC_OK);
        check(rd, {rchal[119:0], rchal[127:120], 128'h0});
        check({ctr, tid, auth}, {16'h1, t0, 1'b1});
        mac_ok = 1'b0;
        send(asm_pkg::KIND_OTHER, asm_pkg::RC_INTEGRITY_ERROR);
        mac_ok = 1'b1;
        check(auth, 1'b0);
        $display("test counter and formats done");
    endtask : t_count

    task automatic t_abort();
        send(asm_pkg::KIND_FIRST_P1, asm_pkg::RC_ADDITIONAL_FRAME);
        send(asm_pkg::KIND_OTHER, asm_pkg::RC_OK);
        check(aex, 1'b0);
        send(asm_pkg::KIND_PART2, asm_pkg::RC_AUTH_ERROR);
        send(asm_pkg::KIND_FIRST_P1, asm_pkg::RC_ADDITIONAL_FRAME);
        corrupt = 1'b1;
        send(asm_pkg::KIND_PART2, asm_pkg::RC_AUTH_ERROR);
        corrupt = 1'b0;
        check({auth, dreq}, 2'b00);
        $display("test abort done");
    endtask : t_abort

    // longest run: counter walked to its top value one command per clock
    task automatic t_wrap();
        t_first(4'h8);
        keeps = 1'b0;
        send(asm_pkg::KIND_OTHER, asm_pkg::RC_OK);
        keeps = 1'b1;
        check({ctr, auth}, {16'h1, 1'b0});
        t_first(4'h8);
        @(negedge clk);
        cmd_valid = 1'b1;
        kind = asm_pkg::KIND_OTHER;
        repeat (65535) @(negedge clk);
        cmd_valid = 1'b0;
        check(ctr, 16'hFFFF);
        send(asm_pkg::KIND_OTHER, asm_pkg::RC_INTEGRITY_ERROR);
        check(auth, 1'b0);
        $display("test counter top done");
    endtask : t_wrap

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // main sequence
    initial begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        check({rc, ctr, auth, aex, civ}, 0);
        t_refuse();
        t_first(4'h4);
        t_count();
        t_abort();
        t_wrap();
        final_report();
    end

    // watchdog at 90000 clocks, well past the expected run
    initial begin
        #2250000;
        bad_count++;
        final_report();
    end
endmodule : testbench
